/* hw/lpmc_pkg.sv */
// package for the low-power mode controller: modes, encodings, wake records
// assumes one 50 MHz clock and synchronous active-high reset
package lpmc_pkg;
    // power modes the sequencer can sit in
    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_SLEEP,
        LPMC_STOP,
        LPMC_STOP_WAKE,
        LPMC_STANDBY,
        LPMC_RESTART
    } lpmc_state_t;

    // software mode request codes
    localparam logic [1:0] LPMC_REQ_NONE    = 2'h0;
    localparam logic [1:0] LPMC_REQ_SLEEP   = 2'h1;
    localparam logic [1:0] LPMC_REQ_STOP    = 2'h2;
    localparam logic [1:0] LPMC_REQ_STANDBY = 2'h3;

    // regulator mode encoding
    localparam logic [1:0] LPMC_REG_MAIN = 2'h0;
    localparam logic [1:0] LPMC_REG_LP   = 2'h1;
    localparam logic [1:0] LPMC_REG_OFF  = 2'h2;

    // external event line count and wakeup pin count
    localparam int LPMC_EXT_LINES = 16;
    localparam int LPMC_WAKEUP_PINS_PINS = 2;

    // cycles for regulator settle before clock delivery / restart hold
    localparam int LPMC_SETTLE_CYC  = 4;
    localparam int LPMC_RESTART_CYC = 8;

    // wake cause bit positions
    localparam int LPMC_WC_EXT     = 0;
    localparam int LPMC_WC_THRESH  = 1;
    localparam int LPMC_WC_PERIPH  = 2;
    localparam int LPMC_WC_RTC     = 3;
    localparam int LPMC_WC_RSTPIN  = 4;
    localparam int LPMC_WC_WDOG    = 5;
    localparam int LPMC_WC_WKPIN   = 6;
    localparam int LPMC_WC_IRQ     = 7;
    localparam logic [7:0] LPMC_WC_RESET = 8'h00;

    // clock and power enables driven to the chip
    typedef struct packed {
        logic cpu_clk_en;
        logic core_clk_en;
        logic pll_en;
        logic int_fast_osc_en;
        logic ext_fast_osc_en;
        logic core_pwr_en;
        logic rtc_wdog_clk_en;
    } lpmc_ctl_t;

    // peripheral stop-wake sources
    typedef struct packed {
        logic rtc;
        logic i2c_addr;
        logic usart;
        logic usb;
        logic cec;
    } lpmc_periph_t;

    // rtc standby/stop wake events
    typedef struct packed {
        logic alarm;
        logic tamper;
        logic timestamp;
    } lpmc_rtc_t;
endpackage

/* hw/lpmc_ctrl.sv */
// low-power mode controller: run, sleep, stop and standby sequencing
// assumes all inputs synchronous to sys_clk_i; wake levels from peripherals
`timescale 1ns/100ps

module lpmc_ctrl #(
    parameter int EXT_LINES = lpmc_pkg::LPMC_EXT_LINES,
    parameter int WAKEUP_PINS_PINS = lpmc_pkg::LPMC_WAKEUP_PINS_PINS
) (
    input  wire logic                   sys_clk_i,     // 50 MHz clock
    input  wire logic                   sys_rst_i,     // sync reset, high
    input  wire logic [1:0]             mode_req_i,    // mode request code
    input  wire logic                   mode_go_i,     // request strobe
    input  wire logic                   stop_lp_reg_i, // stop uses lp reg
    input  wire logic                   irq_event_i,   // cpu irq or event
    input  wire logic [EXT_LINES-1:0]   ext_line_i,    // external lines
    input  wire logic                   thresh_en_i,   // detector enable
    input  wire logic                   thresh_out_i,  // detector output
    input  wire lpmc_pkg::lpmc_periph_t periph_wake_i, // peripheral wakes
    input  wire logic                   i2c_dig_flt_i, // i2c digital filter
    input  wire logic                   osc_req_i,     // periph wants osc
    input  wire lpmc_pkg::lpmc_rtc_t    rtc_evt_i,     // rtc events
    input  wire logic                   ext_rst_n_i,   // reset pin, low
    input  wire logic                   wdog_rst_i,    // watchdog reset
    input  wire logic [WAKEUP_PINS_PINS-1:0]   wakeup_pins_pin_i,    // wakeup pins
    input  wire logic                   cause_clr_i,   // clear wake cause
    output lpmc_pkg::lpmc_ctl_t         ctl_o,         // clock/power enables
    output logic [1:0]                  reg_mode_o,    // regulator mode
    output logic                        periph_osc_o,  // osc given to periph
    output logic                        restart_o,     // full reset request
    output logic                        thresh_irq_o,  // detector interrupt
    output logic [7:0]                  wake_cause_o,  // latched wake cause
    output logic [2:0]                  mode_o         // current mode
);
    import lpmc_pkg::*;

    lpmc_state_t          state;
    lpmc_state_t          next_state;
    logic [1:0]           reg_mode;
    logic [1:0]           next_reg_mode;
    logic [3:0]           cnt;
    logic [3:0]           next_cnt;
    logic [7:0]           cause;
    logic [7:0]           next_cause;
    logic [WAKEUP_PINS_PINS-1:0] wk_prev;
    logic                 osc_given;
    logic                 next_osc_given;
    logic                 thr_prev;
    logic                 thr_irq;
    logic                 next_thr_irq;
    logic [7:0]           stop_src;
    logic [7:0]           stby_src;
    logic [WAKEUP_PINS_PINS-1:0] wk_rise;
    logic                 any_rtc;

    // rising edge detect per wakeup pin
    genvar gi;
    generate
        for (gi = 0; gi < WAKEUP_PINS_PINS; gi++) begin : g_wk
            assign wk_rise[gi] = wakeup_pins_pin_i[gi] & ~wk_prev[gi];
        end
    endgenerate

    assign any_rtc = rtc_evt_i.alarm | rtc_evt_i.tamper
                   | rtc_evt_i.timestamp | periph_wake_i.rtc;

    // stop wake sources; i2c address match masked by digital filter
    always_comb begin
        stop_src = 8'h00;
        stop_src[LPMC_WC_EXT]    = |ext_line_i;
        stop_src[LPMC_WC_THRESH] = thresh_en_i & thresh_out_i;
        stop_src[LPMC_WC_PERIPH] = periph_wake_i.usart
                                 | periph_wake_i.usb
                                 | periph_wake_i.cec
                                 | (periph_wake_i.i2c_addr
                                    & ~i2c_dig_flt_i);
        stop_src[LPMC_WC_RTC]    = any_rtc;
    end

    // standby wake sources
    always_comb begin
        stby_src = 8'h00;
        stby_src[LPMC_WC_RSTPIN] = ~ext_rst_n_i;
        stby_src[LPMC_WC_WDOG]   = wdog_rst_i;
        stby_src[LPMC_WC_WKPIN]  = |wk_rise;
        stby_src[LPMC_WC_RTC]    = any_rtc;
    end

    // mode sequencer next state
    always_comb begin
        next_state     = state;
        next_reg_mode  = reg_mode;
        next_cnt       = cnt;
        next_cause     = cause;
        next_osc_given = osc_given;
        if (cause_clr_i)
            next_cause = LPMC_WC_RESET;
        unique case (state)
            LPMC_RUN: begin
                next_reg_mode = LPMC_REG_MAIN;
                if (mode_go_i) begin
                    unique case (mode_req_i)
                        LPMC_REQ_SLEEP: next_state = LPMC_SLEEP;
                        LPMC_REQ_STOP: begin
                            next_state    = LPMC_STOP;
                            next_reg_mode = stop_lp_reg_i ? LPMC_REG_LP
                                                          : LPMC_REG_MAIN;
                        end
                        LPMC_REQ_STANDBY: begin
                            next_state    = LPMC_STANDBY;
                            next_reg_mode = LPMC_REG_OFF;
                        end
                        default: next_state = LPMC_RUN;
                    endcase
                end
            end
            LPMC_SLEEP: begin
                if (irq_event_i) begin
                    next_state = LPMC_RUN;
                    next_cause = next_cause | 8'h80;
                end
            end
            LPMC_STOP: begin
                if (|stop_src) begin
                    next_state     = LPMC_STOP_WAKE;
                    next_cause     = next_cause | stop_src;
                    next_reg_mode  = LPMC_REG_MAIN;
                    next_cnt       = 4'(LPMC_SETTLE_CYC);
                    next_osc_given = 1'b0;
                end else if (osc_req_i) begin
                    // regulator first, clock only after it settled
                    if (reg_mode == LPMC_REG_LP) begin
                        next_reg_mode = LPMC_REG_MAIN;
                        next_cnt      = 4'(LPMC_SETTLE_CYC);
                    end else if (cnt != 4'h0)
                        next_cnt = cnt - 4'h1;
                    else
                        next_osc_given = 1'b1;
                end else begin
                    next_osc_given = 1'b0;
                    next_reg_mode  = stop_lp_reg_i ? LPMC_REG_LP
                                                   : LPMC_REG_MAIN;
                end
            end
            LPMC_STOP_WAKE: begin
                // clocks return only once regulator is at main
                if (cnt != 4'h0)
                    next_cnt = cnt - 4'h1;
                else
                    next_state = LPMC_RUN;
            end
            LPMC_STANDBY: begin
                if (|stby_src) begin
                    next_state    = LPMC_RESTART;
                    next_cause    = next_cause | stby_src;
                    next_reg_mode = LPMC_REG_MAIN;
                    next_cnt      = 4'(LPMC_RESTART_CYC);
                end
            end
            LPMC_RESTART: begin
                if (cnt != 4'h0)
                    next_cnt = cnt - 4'h1;
                else
                    next_state = LPMC_RUN;
            end
            default: next_state = LPMC_RUN;
        endcase
        // set beats clear: new cause survives a same-cycle clear
    end

    // detector interrupt: rising crossing only when enabled
    always_comb begin
        next_thr_irq = thresh_en_i & thresh_out_i & ~thr_prev;
    end

    // state registers; cause survives standby (standby circuitry)
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state     <= LPMC_RUN;
            reg_mode  <= LPMC_REG_MAIN;
            cnt       <= 4'h0;
            cause     <= LPMC_WC_RESET;
            wk_prev   <= '0;
            osc_given <= 1'b0;
            thr_prev  <= 1'b0;
            thr_irq   <= 1'b0;
        end else begin
            state     <= next_state;
            reg_mode  <= next_reg_mode;
            cnt       <= next_cnt;
            cause     <= next_cause;
            wk_prev   <= wakeup_pins_pin_i;
            osc_given <= next_osc_given;
            thr_prev  <= thresh_en_i & thresh_out_i;
            thr_irq   <= next_thr_irq;
        end
    end

    // clock and power enables decoded from mode
    always_comb begin
        ctl_o = '1;
        ctl_o.rtc_wdog_clk_en = 1'b1;
        unique case (state)
            LPMC_SLEEP: ctl_o.cpu_clk_en = 1'b0;
            LPMC_STOP, LPMC_STOP_WAKE: begin
                ctl_o.cpu_clk_en      = 1'b0;
                ctl_o.core_clk_en     = 1'b0;
                ctl_o.pll_en          = 1'b0;
                ctl_o.int_fast_osc_en = osc_given;
                ctl_o.ext_fast_osc_en = 1'b0;
            end
            LPMC_STANDBY, LPMC_RESTART: begin
                ctl_o.cpu_clk_en      = 1'b0;
                ctl_o.core_clk_en     = 1'b0;
                ctl_o.pll_en          = 1'b0;
                ctl_o.int_fast_osc_en = 1'b0;
                ctl_o.ext_fast_osc_en = 1'b0;
                ctl_o.core_pwr_en     = (state == LPMC_RESTART);
            end
            default: ;
        endcase
    end

    assign reg_mode_o   = reg_mode;
    assign periph_osc_o = osc_given;
    assign restart_o    = (state == LPMC_RESTART);
    assign thresh_irq_o = thr_irq;
    assign wake_cause_o = cause;
    assign mode_o       = state;

    // regulator main at the first edge after reset lets go
    a_reset_main_reg: assert property (@(posedge sys_clk_i)
        $past(sys_rst_i) && !sys_rst_i |-> reg_mode == LPMC_REG_MAIN)
        else $error("regulator not main after reset");

    a_stop_reg_cfg: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_RUN && mode_go_i
        && mode_req_i == LPMC_REQ_STOP |=> reg_mode ==
        ($past(stop_lp_reg_i) ? LPMC_REG_LP : LPMC_REG_MAIN))
        else $error("stop regulator mode not as configured");

    a_standby_off: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_STANDBY |-> reg_mode == LPMC_REG_OFF
        && !ctl_o.core_pwr_en)
        else $error("standby left regulator or core powered");

    a_sleep_cpu_only: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_SLEEP |-> !ctl_o.cpu_clk_en
        && ctl_o.core_clk_en && ctl_o.pll_en)
        else $error("sleep gated more than cpu clock");

    a_sleep_wake: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_SLEEP && irq_event_i
        |=> state == LPMC_RUN)
        else $error("sleep did not resume on event");

    a_stop_clocks: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_STOP |-> !ctl_o.core_clk_en
        && !ctl_o.pll_en && !ctl_o.ext_fast_osc_en)
        else $error("stop left core clocks running");

    a_stop_exit: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_STOP && |ext_line_i
        |=> state == LPMC_STOP_WAKE ##5 state == LPMC_RUN)
        else $error("stop did not exit on external line");

    a_osc_after_main: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) $rose(osc_given) |-> reg_mode == LPMC_REG_MAIN
        && $past(reg_mode) == LPMC_REG_MAIN)
        else $error("oscillator given before main regulator");

    a_standby_exit: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_STANDBY && !ext_rst_n_i
        |=> restart_o ##1 restart_o)
        else $error("standby did not restart on reset pin");

    a_rtc_clk_on: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) ctl_o.rtc_wdog_clk_en)
        else $error("rtc and watchdog clock stopped");

    a_i2c_flt_block: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) i2c_dig_flt_i |-> !(stop_src[LPMC_WC_PERIPH]
        && !periph_wake_i.usart && !periph_wake_i.usb
        && !periph_wake_i.cec))
        else $error("i2c wake with digital filter");

    a_cause_latched: assert property (@(posedge sys_clk_i) disable iff
        (sys_rst_i) state == LPMC_STANDBY && wdog_rst_i
        |=> wake_cause_o[LPMC_WC_WDOG])
        else $error("wake cause not recorded");
endmodule // lpmc_ctrl

/* testbench/lpmc_wake_src.sv */
// far-side model: wake and event sources of pins and peripherals
// assumes the bench picks a source and holds fire_i while it wants it
`timescale 1ns/100ps
module lpmc_wake_src
    import lpmc_pkg::*;
(
    input  wire logic   fire_i,      // assert the chosen source
    input  wire logic [3:0] kind_i,  // which source
    input  wire logic [3:0] line_i,  // external line index
    output logic [15:0] ext_line_o,  // external event lines
    output logic        thresh_o,    // detector output
    output lpmc_periph_t periph_o,   // peripheral wake levels
    output lpmc_rtc_t   rtc_o,       // rtc wake events
    output logic        rst_n_o,     // reset pin, pulled up when idle
    output logic        wdog_o,      // watchdog reset
    output logic [1:0]  wakeup_pins_o       // wakeup pins
);
    // idle levels first; the reset pin rests high through its pull-up
    always_comb begin
        ext_line_o = '0;
        thresh_o   = 1'b0;
        periph_o   = '0;
        rtc_o      = '0;
        rst_n_o    = 1'b1;
        wdog_o     = 1'b0;
        wakeup_pins_o     = 2'b00;
        if (fire_i) begin
            case (kind_i)
                4'h0: ext_line_o[line_i] = 1'b1;
                4'h1: thresh_o = 1'b1;
                4'h2: periph_o.i2c_addr = 1'b1;
                4'h3: periph_o.usart = 1'b1;
                4'h4: periph_o.usb = 1'b1;
                4'h5: periph_o.cec = 1'b1;
                4'h6: rtc_o.alarm = 1'b1;
                4'h7: rtc_o.tamper = 1'b1;
                4'h8: rtc_o.timestamp = 1'b1;
                4'h9: rst_n_o = 1'b0;
                4'ha: wdog_o = 1'b1;
                default: wakeup_pins_o[line_i[0]] = 1'b1; // rising edge
            endcase
        end
    end
endmodule // lpmc_wake_src

/* testbench/low_power_mode_controller_tb_top.sv */
// self-checking bench for the low-power mode controller
// assumes lpmc_pkg and lpmc_ctrl compiled first; wake model beside it
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module low_power_mode_controller_tb_top;
    import lpmc_pkg::*;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, go = 1'b0, lp = 1'b0;
    logic irq = 1'b0, t_en = 1'b0, flt = 1'b0, osc = 1'b0, clr = 1'b0;
    logic fire = 1'b0;
    logic [1:0]   req = 2'h0, wakeup_pins, reg_mode;
    logic [3:0]   kind = 4'h0, idx = 4'h0;
    logic [15:0]  ext;
    logic         t_out, rst_n, wdog, posc, restart, tirq;
    lpmc_periph_t periph;
    lpmc_rtc_t    rtc;
    lpmc_ctl_t    ctl;
    logic [7:0]   cause;
    logic [2:0]   mode;
    int           fail_count = 0, checks = 0, cyc = 0;

    lpmc_ctrl lpmc_ctrl_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .mode_req_i(req), .mode_go_i(go), .stop_lp_reg_i(lp),
        .irq_event_i(irq), .ext_line_i(ext), .thresh_en_i(t_en),
        .thresh_out_i(t_out), .periph_wake_i(periph), .i2c_dig_flt_i(flt),
        .osc_req_i(osc), .rtc_evt_i(rtc), .ext_rst_n_i(rst_n),
        .wdog_rst_i(wdog), .wakeup_pins_pin_i(wakeup_pins), .cause_clr_i(clr),
        .ctl_o(ctl), .reg_mode_o(reg_mode), .periph_osc_o(posc),
        .restart_o(restart), .thresh_irq_o(tirq), .wake_cause_o(cause),
        .mode_o(mode));
    lpmc_wake_src lpmc_wake_src_inst (.fire_i(fire), .kind_i(kind),
        .line_i(idx), .ext_line_o(ext), .thresh_o(t_out),
        .periph_o(periph), .rtc_o(rtc), .rst_n_o(rst_n), .wdog_o(wdog),
        .wakeup_pins_o(wakeup_pins));

    // 50 MHz clock
    always #10 sys_clk_i = ~sys_clk_i;

    // hang guard, far above the longest expected run
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // expected cause bit for each source kind of the wake model
    function automatic logic [7:0] exp_cause(input logic [3:0] k);
        exp_cause = 8'h00;
        case (k)
            4'h0: exp_cause[LPMC_WC_EXT] = 1'b1;
            4'h1: exp_cause[LPMC_WC_THRESH] = 1'b1;
            4'h2, 4'h3, 4'h4, 4'h5: exp_cause[LPMC_WC_PERIPH] = 1'b1;
            4'h6, 4'h7, 4'h8: exp_cause[LPMC_WC_RTC] = 1'b1;
            4'h9: exp_cause[LPMC_WC_RSTPIN] = 1'b1;
            4'ha: exp_cause[LPMC_WC_WDOG] = 1'b1;
            default: exp_cause[LPMC_WC_WKPIN] = 1'b1;
        endcase
    endfunction

    // bounded wait for a mode, looked at on the falling edge
    task automatic wait_mode(input lpmc_state_t m, input int lim);
        int n;
        n = 0;
        while (mode !== 3'(m) && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        `CHK("mode", 3'(m), mode)
    endtask

    // one strobed request; the new mode is visible after the taking edge
    task automatic request(input logic [1:0] code, input logic use_lp);
        @(posedge sys_clk_i);
        go  <= 1'b1;
        req <= code;
        lp  <= use_lp;
        @(posedge sys_clk_i);
        go <= 1'b0;
        @(negedge sys_clk_i);
    endtask

    // enter a low-power mode and check what it switches off
    task automatic enter(input logic [1:0] code, input logic use_lp);
        logic [1:0] er;
        er = use_lp ? LPMC_REG_LP : LPMC_REG_MAIN;
        request(code, use_lp);
        if (code == LPMC_REQ_STOP) begin
            `CHK("stop_mode", 3'(LPMC_STOP), mode)
            `CHK("stop_reg", er, reg_mode)
            `CHK("stop_ctl", lpmc_ctl_t'(7'h03), ctl)
        end else begin
            `CHK("sb_mode", 3'(LPMC_STANDBY), mode)
            `CHK("sb_reg", LPMC_REG_OFF, reg_mode)
            `CHK("sb_ctl", lpmc_ctl_t'(7'h01), ctl)
        end
    endtask

    // pulse the clear strobe and check the record is empty
    task automatic clear_cause();
        @(posedge sys_clk_i);
        clr <= 1'b1;
        @(posedge sys_clk_i);
        clr <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("cleared", LPMC_WC_RESET, cause)
    endtask

    // fire one source, follow the exit path back to run
    task automatic wake(input logic [3:0] k, input logic sb);
        int n;
        logic [2:0] low;
        low = sb ? 3'(LPMC_STANDBY) : 3'(LPMC_STOP);
        @(posedge sys_clk_i);
        kind <= k;
        fire <= 1'b1;
        n = 0;
        @(negedge sys_clk_i);
        while (mode === low && n < 10) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (sb)
            `CHK("restart", 1'b1, restart)
        else
            `CHK("wake_reg", LPMC_REG_MAIN, reg_mode)
        @(posedge sys_clk_i);
        fire <= 1'b0;
        wait_mode(LPMC_RUN, 20);
        `CHK("cause", exp_cause(k), cause)
        `CHK("run_ctl", lpmc_ctl_t'(7'h7f), ctl)
        `CHK("run_reg", LPMC_REG_MAIN, reg_mode)
        clear_cause();
    endtask

    // hold the detector output high a few cycles and count interrupts
    task automatic thresh_pulses(input logic en, input int exp);
        int c;
        c = 0;
        @(posedge sys_clk_i);
        t_en <= en;
        kind <= 4'h1;
        fire <= 1'b1;
        repeat (6) begin
            @(negedge sys_clk_i);
            c += int'(tirq !== 1'b0); // an unknown counts as a pulse
        end
        @(posedge sys_clk_i);
        fire <= 1'b0;
        `CHK("thresh_irq", exp, c)
    endtask

    initial begin
        logic sb;
        logic [3:0] k;
        void'($urandom(33855));
        repeat (6) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("rst_mode", 3'(LPMC_RUN), mode)
        `CHK("rst_reg", LPMC_REG_MAIN, reg_mode)
        `CHK("rst_ctl", lpmc_ctl_t'(7'h7f), ctl)
        `CHK("rst_cause", LPMC_WC_RESET, cause)
        request(LPMC_REQ_NONE, 1'b0);
        `CHK("none_mode", 3'(LPMC_RUN), mode) // code zero is ignored
        // sleep stops only the cpu clock; an interrupt resumes
        request(LPMC_REQ_SLEEP, 1'b0);
        `CHK("sleep_ctl", lpmc_ctl_t'(7'h3f), ctl)
        @(posedge sys_clk_i);
        irq <= 1'b1;
        wait_mode(LPMC_RUN, 10);
        `CHK("sleep_cause", 8'h80, cause)
        @(posedge sys_clk_i);
        irq <= 1'b0;
        clear_cause(); // sleep bit must not leak into later cause checks
        thresh_pulses(1'b0, 0);
        thresh_pulses(1'b1, 1);
        // a request outside run is dropped
        enter(LPMC_REQ_STOP, 1'b1);
        request(LPMC_REQ_STANDBY, 1'b1); // keep lp so the osc path is taken
        `CHK("refused", 3'(LPMC_STOP), mode)
        `CHK("refused_reg", LPMC_REG_LP, reg_mode)
        // oscillator request in low-power stop: regulator first
        @(posedge sys_clk_i);
        osc <= 1'b1;
        repeat (12) begin
            @(negedge sys_clk_i);
            if (posc === 1'b1 || ctl.int_fast_osc_en === 1'b1)
                `CHK("osc_reg", LPMC_REG_MAIN, reg_mode)
        end
        `CHK("osc_given", 1'b1, posc)
        `CHK("osc_on", 1'b1, ctl.int_fast_osc_en)
        @(posedge sys_clk_i);
        osc <= 1'b0;
        wake(4'h0, 1'b0);
        // digital filter blocks address wake
        enter(LPMC_REQ_STOP, 1'b0);
        @(posedge sys_clk_i);
        flt  <= 1'b1;
        kind <= 4'h2;
        fire <= 1'b1;
        repeat (12) @(negedge sys_clk_i);
        `CHK("i2c_blocked", 3'(LPMC_STOP), mode)
        @(posedge sys_clk_i);
        fire <= 1'b0;
        flt  <= 1'b0;
        wake(4'h2, 1'b0);
        // every source in one allowed mode (rtc kinds in stop only), then random mixes
        for (int i = 0; i < 12; i++) begin
            sb = (i > 8);
            enter(sb ? LPMC_REQ_STANDBY : LPMC_REQ_STOP, i[0]);
            wake(4'(i), sb);
        end
        repeat (16) begin
            sb = 1'($urandom % 2);
            k  = sb ? 4'(6 + $urandom % 6) : 4'($urandom % 9);
            idx <= 4'($urandom % 16);
            enter(sb ? LPMC_REQ_STANDBY : LPMC_REQ_STOP, 1'($urandom % 2));
            wake(k, sb);
        end
        // a reset in the middle of low-power stop returns to main run
        enter(LPMC_REQ_STOP, 1'b1);
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("rst2_mode", 3'(LPMC_RUN), mode)
        `CHK("rst2_reg", LPMC_REG_MAIN, reg_mode)
        `CHK("rst2_ctl", lpmc_ctl_t'(7'h7f), ctl)
        stop_test();
    end
endmodule // low_power_mode_controller_tb_top
